// [uinm_consts.svh]
// Register offsets, field positions and reset values of the serial port
// interrupt, modem and network section. Assumes an 8 ns clock and a 4-bit word address.
//
// Functional notes
// - Enable bit 3 lets any modem change flag raise the interrupt.
// - Enable bit 2 lets line error flags, status bits 3 to 1, interrupt.
// - Enable bit 1 gates the transmit buffer empty interrupt.
// - Enable bit 0 gates the receive buffer full interrupt.
// - Line status reports code 11, top priority, cleared by line status read.
// - Receive full reports code 10, priority 2, cleared by receive data read.
// - Transmit empty reports 01, cleared by transmit write or by a first identification register read that reports it.
// - Modem status reports 00, lowest priority, cleared by modem status read.
// - Loop-back forces serial output high and routes modem outputs to inputs.
// - Control bit 1 drives the send request pin inverted.
// - Control bit 0 drives the terminal ready pin inverted.
// - Carrier, set-ready and clear-to-send change flags set on change, clear on read.
// - Ring flag sets on ring input rising, clears on modem status read.
// - Divide bit 15 selects the fractional baud generator.
// - Multiplier in bits 12:11, zero means four; fraction in bits 10:0.
// - Network mode is active only while network control bit 7 is set.
// - Network mode disables parity checking; parity position carries the marker.
// - Network control bit 0 marks the sent word as address or data.
// - Bit 6 enables nine-bit transmit, only meaningful in network mode.
// - Bit 5 enables nine-bit receive, only meaningful in network mode.
// - Bit 3 selects nine-bit data word; software keeps transmit enable clear.
// - Bit 2 enables the serial output driver in network mode, else the pin floats; outside network mode it always drives.
// - An 8-bit node address register; a matching received address raises status.
// - Network identification reports match as 110, address sent empty as 101.
`ifndef UINM_CONSTS_SVH
`define UINM_CONSTS_SVH
`define UINM_A_IEN0 4'h0
`define UINM_A_IID0 4'h1
`define UINM_A_CON1 4'h2
`define UINM_A_STA1 4'h3
`define UINM_A_DIV2 4'h4
`define UINM_A_IEN1 4'h5
`define UINM_A_IID1 4'h6
`define UINM_A_ADR 4'h7
`define UINM_A_RX 4'h8
`define UINM_A_TX 4'h9
`define UINM_A_STA0 4'hA
`define UINM_B_MODEM_EN 3
`define UINM_B_LINE_EN 2
`define UINM_B_TXE_EN 1
`define UINM_B_RXF_EN 0
`define UINM_B_LOOP 4
`define UINM_B_OUT2 3
`define UINM_B_OUT1 2
`define UINM_B_RTS 1
`define UINM_B_DTR 0
`define UINM_B_FRAC_BAUD_EN 15
`define UINM_R_FBM 12:11
`define UINM_R_FBN 10:0
`define UINM_B_NETMODE 7
`define UINM_B_TX9 6
`define UINM_B_RX9 5
`define UINM_B_NETIRQ 4
`define UINM_B_WORD9 3
`define UINM_B_DRV 2
`define UINM_B_NET_ADDR_IRQ_POLARITY 1
`define UINM_B_NAB 0
`define UINM_R_LINE_ERR 3:1
`define UINM_FBM_ZERO_MULT 3'h4
`define UINM_RST_8 8'h00
`define UINM_RST_16 16'h0000
`define UINM_RST_IID 8'h01
`endif

// [uinm_pkg.sv]
// Types shared by the serial port interrupt, modem and network section.
// Assumes the constants header is included by the design file.
package uinm_pkg;
   // Identification codes, pending bit low; priority is fixed by the selection logic.
   typedef enum logic [3:0] {
      UINM_ID_NONE = 4'b0001,
      UINM_ID_LINE = 4'b0110,
      UINM_ID_RXF = 4'b0100,
      UINM_ID_MATCH = 4'b1100,
      UINM_ID_ADDRTX = 4'b1010,
      UINM_ID_TXE = 4'b0010,
      UINM_ID_MODEM = 4'b0000
   } uinm_id_t;
endpackage : uinm_pkg

// [uinm_top.sv]
// Interrupt, modem control and network address section of a serial port.
// Assumes the receiver, transmitter and baud generators sit outside and
// exchange one-cycle event pulses and levels with this block on clk.
`timescale 1ns/1ps
`include "uinm_consts.svh"
module uinm_top (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Receiver and transmitter core.
   input wire logic [7:0] line_status,
   input wire logic line_err_evt,
   input wire logic rx_full_evt,
   input wire logic [8:0] rx_word,
   input wire logic tx_empty_evt,
   input wire logic tx_serial,
   input wire logic serial_in,
   input wire logic parity_en_in,
   output logic rx_serial,
   output logic rx_data_read,
   output logic tx_data_write,
   output logic [7:0] tx_data,
   output logic parity_check_en,
   output logic parity_is_marker,
   output logic tx_ninth_bit,
   output logic ninebit_tx_en,
   output logic ninebit_rx_en,
   output logic ninebit_word,
   // Baud generator selection.
   output logic frac_baud_en,
   output logic [2:0] frac_mult,
   output logic [10:0] frac_num,
   // Serial line and modem pins.
   output logic serial_out,
   output logic serial_out_oe,
   output logic rts_n,
   output logic dtr_n,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ring_in_n,
   input wire logic dcd_n,
   // Interrupt request.
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and decode.

   logic [7:0] irq_enable_r;
   logic [7:0] modem_ctrl_r;
   logic [15:0] frac_div_r;
   logic [7:0] net_ctrl_r;
   logic [7:0] node_addr_r;
   logic [3:0] modem_delta_r;
   logic [3:0] modem_prev_r;
   logic line_pend_r;
   logic rxf_pend_r;
   logic match_pend_r;
   logic txe_pend_r;
   logic addr_sent_r;
   logic [15:0] rdata_r;
   logic [7:0] tx_data_r;
   logic rx_read_r;
   logic tx_write_r;
   logic netmode;
   logic loopback;
   logic [3:0] modem_now;
   logic [3:0] modem_delta_set;
   logic match_hit;
   logic en_line;
   logic en_rxf;
   logic en_txe;
   logic en_modem;
   uinm_pkg::uinm_id_t id_code;
   logic [7:0] iid0_val;
   logic [7:0] iid1_val;
   logic wr_ien0;
   logic wr_con1;
   logic wr_div2;
   logic wr_ien1;
   logic wr_adr;
   logic wr_tx;
   logic rd_iid0;
   logic rd_sta1;
   logic rd_rx;
   logic rd_sta0;

   // Strobe decode; unmapped offsets read zero and ignore writes.
   assign wr_ien0 = reg_wr && (reg_addr == `UINM_A_IEN0);
   assign wr_con1 = reg_wr && (reg_addr == `UINM_A_CON1);
   assign wr_div2 = reg_wr && (reg_addr == `UINM_A_DIV2);
   assign wr_ien1 = reg_wr && (reg_addr == `UINM_A_IEN1);
   assign wr_adr = reg_wr && (reg_addr == `UINM_A_ADR);
   assign wr_tx = reg_wr && (reg_addr == `UINM_A_TX);
   assign rd_iid0 = reg_rd && (reg_addr == `UINM_A_IID0);
   assign rd_sta1 = reg_rd && (reg_addr == `UINM_A_STA1);
   assign rd_rx = reg_rd && (reg_addr == `UINM_A_RX);
   assign rd_sta0 = reg_rd && (reg_addr == `UINM_A_STA0);

   // Interrupt enable register.
   always_ff @(posedge clk)
   begin
      if (srst)
         irq_enable_r <= `UINM_RST_8;
      else if (wr_ien0)
         irq_enable_r <= reg_wdata[7:0];
   end

   // Modem control register; unused bits are kept so loop-back sees them.
   always_ff @(posedge clk)
   begin
      if (srst)
         modem_ctrl_r <= `UINM_RST_8;
      else if (wr_con1)
         modem_ctrl_r <= reg_wdata[7:0];
   end

   // Fractional divide register.
   always_ff @(posedge clk)
   begin
      if (srst)
         frac_div_r <= `UINM_RST_16;
      else if (wr_div2)
         frac_div_r <= reg_wdata;
   end

   // Network control register.
   always_ff @(posedge clk)
   begin
      if (srst)
         net_ctrl_r <= `UINM_RST_8;
      else if (wr_ien1)
         net_ctrl_r <= reg_wdata[7:0];
   end

   // Node address register.
   always_ff @(posedge clk)
   begin
      if (srst)
         node_addr_r <= `UINM_RST_8;
      else if (wr_adr)
         node_addr_r <= reg_wdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Modem pins and status.

   assign loopback = modem_ctrl_r[`UINM_B_LOOP];
   assign netmode = net_ctrl_r[`UINM_B_NETMODE];

   // Pins idle high in loop-back so the far modem sees nothing.
   assign rts_n = loopback | ~modem_ctrl_r[`UINM_B_RTS];
   assign dtr_n = loopback | ~modem_ctrl_r[`UINM_B_DTR];

   // Status in true sense, order carrier, ring, set-ready, clear-to-send.
   always_comb
   begin
      if (loopback)
      begin
         modem_now = {modem_ctrl_r[`UINM_B_OUT2], modem_ctrl_r[`UINM_B_OUT1],
                      modem_ctrl_r[`UINM_B_DTR], modem_ctrl_r[`UINM_B_RTS]};
      end
      else
      begin
         modem_now = {~dcd_n, ~ring_in_n, ~dsr_n, ~cts_n};
      end
   end

   // Change detection per status input; ring flags only the pin's rising edge.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_delta
         if (gi == 2)
         begin : g_ring
            assign modem_delta_set[gi] = modem_prev_r[gi] & ~modem_now[gi];
         end
         else
         begin : g_level
            assign modem_delta_set[gi] = modem_prev_r[gi] ^ modem_now[gi];
         end
      end
   endgenerate

   // Previous status sample.
   always_ff @(posedge clk)
   begin
      if (srst)
         modem_prev_r <= 4'h0;
      else
         modem_prev_r <= modem_now;
   end

   // Change flags clear on status read, but a change in that cycle survives.
   always_ff @(posedge clk)
   begin
      if (srst)
         modem_delta_r <= 4'h0;
      else if (rd_sta1)
         modem_delta_r <= modem_delta_set;
      else
         modem_delta_r <= modem_delta_r | modem_delta_set;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt sources.

   // Line errors latch; a line status read clears unless a new error arrives.
   always_ff @(posedge clk)
   begin
      if (srst)
         line_pend_r <= 1'b0;
      else if (line_err_evt)
         line_pend_r <= 1'b1;
      else if (rd_sta0)
         line_pend_r <= 1'b0;
   end

   // Address match needs nine-bit receive with the marker seen as address.
   assign match_hit = rx_full_evt && netmode && net_ctrl_r[`UINM_B_RX9] &&
                      net_ctrl_r[`UINM_B_NETIRQ] &&
                      (rx_word[8] ^ net_ctrl_r[`UINM_B_NET_ADDR_IRQ_POLARITY]) &&
                      (rx_word[7:0] == node_addr_r);

   // Receive full and match pending; a receive data read clears both.
   always_ff @(posedge clk)
   begin
      if (srst)
         rxf_pend_r <= 1'b0;
      else if (rx_full_evt)
         rxf_pend_r <= 1'b1;
      else if (rd_rx)
         rxf_pend_r <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         match_pend_r <= 1'b0;
      else if (match_hit)
         match_pend_r <= 1'b1;
      else if (rd_rx || rx_full_evt)
         match_pend_r <= 1'b0;
   end

   // Transmit empty clears on a data write or on a first identification register
   // read that reports it; a new empty event in that cycle wins.
   always_ff @(posedge clk)
   begin
      if (srst)
         txe_pend_r <= 1'b0;
      else if (tx_empty_evt)
         txe_pend_r <= 1'b1;
      else if (wr_tx || (rd_iid0 && (id_code == uinm_pkg::UINM_ID_TXE ||
               id_code == uinm_pkg::UINM_ID_ADDRTX)))
         txe_pend_r <= 1'b0;
   end

   // Remembers whether the last written word went out marked as an address.
   always_ff @(posedge clk)
   begin
      if (srst)
         addr_sent_r <= 1'b0;
      else if (wr_tx)
         addr_sent_r <= netmode & net_ctrl_r[`UINM_B_NAB];
   end

   // Enabled sources.
   assign en_line = line_pend_r & irq_enable_r[`UINM_B_LINE_EN];
   assign en_rxf = (rxf_pend_r | match_pend_r) & irq_enable_r[`UINM_B_RXF_EN];
   assign en_txe = txe_pend_r & irq_enable_r[`UINM_B_TXE_EN];
   assign en_modem = (|modem_delta_r) & irq_enable_r[`UINM_B_MODEM_EN];

   // Fixed priority: line, receive, transmit, modem.
   always_comb
   begin
      if (en_line)
         id_code = uinm_pkg::UINM_ID_LINE;
      else if (en_rxf && match_pend_r && netmode)
         id_code = uinm_pkg::UINM_ID_MATCH;
      else if (en_rxf)
         id_code = uinm_pkg::UINM_ID_RXF;
      else if (en_txe && addr_sent_r)
         id_code = uinm_pkg::UINM_ID_ADDRTX;
      else if (en_txe)
         id_code = uinm_pkg::UINM_ID_TXE;
      else if (en_modem)
         id_code = uinm_pkg::UINM_ID_MODEM;
      else
         id_code = uinm_pkg::UINM_ID_NONE;
   end

   // The first identification register carries only the two-bit code and the pending bit.
   assign iid0_val = {5'h00, id_code[2:1], id_code[0]};
   assign iid1_val = {4'h0, id_code};

   // Level output; stays high while any enabled source is uncleared.
   assign irq = en_line | en_rxf | en_txe | en_modem;

   ////////////////////////////////////////////////////////////////////////////
   // Read data and side-effect pulses.

   // Read data lands one cycle after the strobe.
   always_ff @(posedge clk)
   begin
      if (srst)
         rdata_r <= `UINM_RST_16;
      else if (reg_rd)
      begin
         case (reg_addr)
            `UINM_A_IEN0: rdata_r <= {8'h00, 4'h0, irq_enable_r[3:0]};
            `UINM_A_IID0: rdata_r <= {8'h00, iid0_val};
            `UINM_A_CON1: rdata_r <= {8'h00, modem_ctrl_r};
            `UINM_A_STA1: rdata_r <= {8'h00, modem_now, modem_delta_r};
            `UINM_A_DIV2: rdata_r <= {frac_div_r[15], 2'b00, frac_div_r[12:0]};
            `UINM_A_IEN1: rdata_r <= {8'h00, net_ctrl_r};
            `UINM_A_IID1: rdata_r <= {8'h00, iid1_val};
            `UINM_A_ADR: rdata_r <= {8'h00, node_addr_r};
            `UINM_A_RX: rdata_r <= {7'h00, rx_word};
            `UINM_A_STA0: rdata_r <= {8'h00, line_status};
            default: rdata_r <= `UINM_RST_16;
         endcase
      end
      else
         rdata_r <= `UINM_RST_16;
   end
   assign reg_rdata = rdata_r;

   // Notify the core of a data read or write, one cycle after the strobe.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rx_read_r <= 1'b0;
         tx_write_r <= 1'b0;
      end
      else
      begin
         rx_read_r <= rd_rx;
         tx_write_r <= wr_tx;
      end
   end

   // Transmit data holding.
   always_ff @(posedge clk)
   begin
      if (srst)
         tx_data_r <= `UINM_RST_8;
      else if (wr_tx)
         tx_data_r <= reg_wdata[7:0];
   end

   assign rx_data_read = rx_read_r;
   assign tx_data_write = tx_write_r;
   assign tx_data = tx_data_r;

   ////////////////////////////////////////////////////////////////////////////
   // Serial line, baud and word format controls.

   // Loop-back returns the transmit stream to the receiver and idles the line.
   assign rx_serial = loopback ? tx_serial : serial_in;
   assign serial_out = loopback | tx_serial;
   // Outside network mode the driver is always on.
   assign serial_out_oe = ~netmode | net_ctrl_r[`UINM_B_DRV];

   assign parity_check_en = parity_en_in & ~netmode;
   assign parity_is_marker = netmode;
   assign tx_ninth_bit = addr_sent_r;
   // Nine-bit modes only take effect inside network mode.
   assign ninebit_tx_en = netmode & net_ctrl_r[`UINM_B_TX9];
   assign ninebit_rx_en = netmode & net_ctrl_r[`UINM_B_RX9];
   assign ninebit_word = netmode & net_ctrl_r[`UINM_B_WORD9];

   assign frac_baud_en = frac_div_r[`UINM_B_FRAC_BAUD_EN];
   assign frac_mult = (frac_div_r[`UINM_R_FBM] == 2'b00) ? `UINM_FBM_ZERO_MULT
                      : {1'b0, frac_div_r[`UINM_R_FBM]};
   assign frac_num = frac_div_r[`UINM_R_FBN];

endmodule : uinm_top

// [uinm_assertions.sv]
// Checker for the serial port interrupt, modem and network section.
// Assumes it is bound to uinm_top and sees only its ports.
`timescale 1ns/1ps
module uinm_chk (
   // Clock, reset and register port.
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Core side.
   input wire logic rx_full_evt,
   input wire logic tx_serial,
   input wire logic parity_en_in,
   input wire logic rx_serial,
   input wire logic parity_check_en,
   input wire logic parity_is_marker,
   input wire logic frac_baud_en,
   input wire logic [2:0] frac_mult,
   input wire logic [10:0] frac_num,
   // Pins and interrupt.
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic rts_n,
   input wire logic dtr_n,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ring_in_n,
   input wire logic dcd_n,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
////////////////////////////////////////////////////////////////////////////////
   // Shadows of the mode bits, loaded on the same edge as the design's copies.
   logic [3:0] ien_r;
   logic [7:0] net_r;
   logic loop_r;
   logic up_r;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ien_r <= 4'h0;
         net_r <= 8'h00;
         loop_r <= 1'b0;
         up_r <= 1'b0;
      end
      else
      begin
         up_r <= 1'b1;
         if (reg_wr && reg_addr == 4'h0)
            ien_r <= reg_wdata[3:0];
         if (reg_wr && reg_addr == 4'h5)
            net_r <= reg_wdata[7:0];
         if (reg_wr && reg_addr == 4'h2)
            loop_r <= reg_wdata[4];
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // A modem status read with still pins; the first cycle after reset is skipped
   // because the change detector may legally fire there.
   sequence s_sta1_rd;
      reg_rd && reg_addr == 4'h3 && up_r && !loop_r && $stable({cts_n, dsr_n, ring_in_n, dcd_n});
   endsequence
   a_pins_inverted:
      assert property (reg_wr && reg_addr == 4'h2 && !reg_wdata[4]
         |=> {rts_n, dtr_n} == ~$past(reg_wdata[1:0])) else $error("modem pins not inverted");
   a_loop_route:
      assert property (loop_r |-> serial_out && rts_n && dtr_n && rx_serial == tx_serial)
      else $error("loop-back routing wrong");
   a_frac_fields:
      assert property (reg_wr && reg_addr == 4'h4 |=> frac_baud_en == $past(reg_wdata[15])
         && frac_num == $past(reg_wdata[10:0]) && frac_mult == ($past(reg_wdata[12:11]) == 2'b00
         ? 3'h4 : {1'b0, $past(reg_wdata[12:11])})) else $error("divide fields wrong");
   a_net_parity:
      assert property (parity_is_marker == net_r[7] && parity_check_en == (parity_en_in && !net_r[7]))
      else $error("parity use wrong");
   a_drv_float:
      assert property (serial_out_oe == (!net_r[7] || net_r[2])) else $error("driver enable wrong");
   a_irq_masked:
      assert property (ien_r == 4'h0 |-> !irq) else $error("irq with all sources off");
   a_rxf_irq:
      assert property (rx_full_evt && ien_r[0] && !reg_wr |=> irq) else $error("no receive irq");
   a_modem_irq:
      assert property ($changed(cts_n) && ien_r[3] && !loop_r && !reg_wr && up_r |=> irq)
      else $error("no modem irq");
   a_flag_clear:
      assert property (s_sta1_rd ##1 s_sta1_rd |=> reg_rdata[3:0] == 4'h0)
      else $error("change flags not cleared");
endmodule : uinm_chk

bind uinm_top uinm_chk uinm_chk_i (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .rx_full_evt, .tx_serial, .parity_en_in, .rx_serial, .parity_check_en,
   .parity_is_marker, .frac_baud_en, .frac_mult, .frac_num, .serial_out, .serial_out_oe,
   .rts_n, .dtr_n, .cts_n, .dsr_n, .ring_in_n, .dcd_n, .irq);

// [uinm_modem_model.sv]
// Remote modem and line partner of the serial port section.
// Assumes the bench sets the wanted levels; pins move on the following edge.
`timescale 1ns/1ps
module uinm_modem_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Wanted asserted levels: carrier, ring, set-ready, clear-to-send.
   input wire logic [3:0] want,
   // Serial line from the port.
   input wire logic serial_out,
   input wire logic serial_out_oe,
   // Active-low modem pins and the echoed line.
   output logic cts_n,
   output logic dsr_n,
   output logic ring_in_n,
   output logic dcd_n,
   output logic serial_in
);
   // The line has a pull-up, so a floating driver is seen as idle high.
   always_ff @(posedge clk)
   begin
      {dcd_n, ring_in_n, dsr_n, cts_n} <= srst ? 4'hF : ~want;
      serial_in <= serial_out_oe ? serial_out : 1'b1;
   end
endmodule : uinm_modem_model

// [tb_uinm_top.sv]
// Self-checking bench for the serial port interrupt, modem and network section.
// Assumes the design, its checker and the modem model are compiled first.
`timescale 1ns/1ps
module tb_uinm_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] line_status = 8'h0A;
   logic line_err_evt = 1'b0;
   logic rx_full_evt = 1'b0;
   logic [8:0] rx_word = 9'h000;
   logic tx_empty_evt = 1'b0;
   logic tx_serial = 1'b1;
   logic parity_en_in = 1'b1;
   logic [3:0] want = 4'h0;
   logic [15:0] reg_rdata;
   logic [7:0] tx_data;
   logic [2:0] frac_mult;
   logic serial_in, serial_out, serial_out_oe, rts_n, dtr_n, cts_n, dsr_n, ring_in_n, dcd_n;
   logic irq, tx_ninth_bit, rx_serial, rx_data_read, tx_data_write;
   logic ninebit_tx_en, ninebit_rx_en, ninebit_word;
   logic [15:0] v, v1;
   logic [3:0] ra [5] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h7};
   // Loop-back stays out of the random pass: it would leave change flags behind.
   logic [15:0] rm [5] = '{16'h000F, 16'h000F, 16'h9FFF, 16'h00FF, 16'h00FF};
   int n_fail = 0;
   int n_tests = 0;
   int seed = 32'h87d0;
   int pend = 0;

   uinm_top uinm_top_i (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .line_status, .line_err_evt, .rx_full_evt, .rx_word, .tx_empty_evt, .tx_serial,
      .serial_in, .parity_en_in, .rx_serial, .rx_data_read, .tx_data_write, .tx_data,
      .parity_check_en(), .parity_is_marker(), .tx_ninth_bit, .ninebit_tx_en,
      .ninebit_rx_en, .ninebit_word, .frac_baud_en(), .frac_mult, .frac_num(),
      .serial_out, .serial_out_oe, .rts_n, .dtr_n, .cts_n, .dsr_n, .ring_in_n, .dcd_n, .irq);
   uinm_modem_model uinm_modem_model_i (.clk, .srst, .want, .serial_out, .serial_out_oe,
      .cts_n, .dsr_n, .ring_in_n, .dcd_n, .serial_in);
////////////////////////////////////////////////////////////////////////////////
   // Free-running 8 ns clock.
   initial
   begin
      forever #4 clk = ~clk;
   end

   // Model code: highest pending source first (line 8, receive 4, transmit 2, modem 1).
   function automatic logic [15:0] iid(input int p);
      if (p[3]) return 16'h0006;
      if (p[2]) return 16'h0004;
      if (p[1]) return 16'h0002;
      if (p[0]) return 16'h0000;
      return 16'h0001;
   endfunction : iid

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Register write; returns mid-cycle so that settled outputs can be sampled.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(negedge clk);
   endtask : wr

   // Register read compared with the model; the data stand one cycle only.
   task automatic rc(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, e);
   endtask : rc

   // Core events: bit 3 line error, 2 receive full, 1 transmit empty, 0 toggles clear-to-send.
   task automatic ev(input logic [3:0] m, input logic [8:0] w);
      @(posedge clk);
      line_err_evt <= m[3];
      rx_full_evt <= m[2];
      tx_empty_evt <= m[1];
      rx_word <= w;
      want <= want ^ {3'b000, m[0]};
      @(posedge clk);
      line_err_evt <= 1'b0;
      rx_full_evt <= 1'b0;
      tx_empty_evt <= 1'b0;
      repeat (2) @(negedge clk);
      pend |= m;
   endtask : ev

   // Partner levels change, then time for the pins and flags to settle.
   task automatic mw(input logic [3:0] w);
      @(posedge clk);
      want <= w;
      repeat (3) @(posedge clk);
   endtask : mw

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
////////////////////////////////////////////////////////////////////////////////
   // Cuts a hung run short.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end

   // Main sequence.
   initial
   begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 8; a++)
         rc(a[3:0], (a == 1 || a == 6) ? 16'h0001 : 16'h0000);
      rc(4'hB, 16'h0000);
      chk(16'({rts_n, dtr_n, irq, frac_mult}), 16'h0034);
      foreach (ra[i])
      begin
         v = 16'($random(seed)) & rm[i];
         wr(ra[i], v);
         rc(ra[i], v);
      end
      wr(4'h2, 16'h0000);
      wr(4'h5, 16'h0000);
      wr(4'h1, 16'hFFFF);
      wr(4'hC, 16'hFFFF);
      rc(4'h1, 16'h0001);
      rc(4'hC, 16'h0000);
      $display("test registers done");
      // All four sources at once drain in priority order.
      wr(4'h0, 16'h000F);
      v = 16'($random(seed)) & 16'h00FF;
      ev(4'hF, v[8:0]);
      chk(16'(irq), 16'h0001);
      rc(4'h1, iid(pend));
      rc(4'hA, 16'h000A);
      pend &= ~8;
      rc(4'h1, iid(pend));
      rc(4'h8, v);
      pend &= ~4;
      rc(4'h1, iid(pend));
      pend &= ~2;
      rc(4'h1, iid(pend));
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= 4'h3;
      repeat (2) @(negedge clk);
      v = reg_rdata;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v1 = reg_rdata;
      chk(v, 16'h0011);
      chk(v1, 16'h0010);
      pend &= ~1;
      rc(4'h1, iid(pend));
      chk(16'(irq), 16'h0000);
      $display("test priority done");
      // Masked sources stay quiet until enabled.
      wr(4'h0, 16'h0000);
      ev(4'hE, 9'h0A5);
      chk(16'(irq), 16'h0000);
      wr(4'h0, 16'h0004);
      chk(16'(irq), 16'h0001);
      wr(4'h0, 16'h000F);
      rc(4'hA, 16'h000A);
      rc(4'h8, 16'h00A5);
      rc(4'h1, 16'h0002);
      ev(4'h2, 9'h000);
      chk(16'(irq), 16'h0001);
      v = 16'($random(seed)) & 16'h00FF;
      wr(4'h9, v);
      rc(4'h1, 16'h0001);
      chk(16'(tx_data), v);
      pend = 0;
      $display("test masking done");
      // Ring trailing edge, then carrier and set-ready changes.
      mw(4'h5);
      rc(4'h3, 16'h0050);
      mw(4'h1);
      rc(4'h3, 16'h0014);
      mw(4'hB);
      rc(4'h3, 16'h00BA);
      // Loop-back routes outputs to inputs and holds the line high.
      @(posedge clk);
      tx_serial <= 1'b0;
      wr(4'h2, 16'h001F);
      chk(16'({rts_n, dtr_n, serial_out}), 16'h0007);
      rc(4'h3, 16'h00F0);
      wr(4'h2, 16'h0010);
      rc(4'h3, 16'h000F);
      wr(4'h2, 16'h0003);
      chk(16'({rts_n, dtr_n, serial_out}), 16'h0000);
      rc(4'h3, 16'h00BB);
      $display("test modem done");
      // Address match, then a non-matching address word.
      wr(4'h7, 16'h005A);
      wr(4'h5, 16'h00B4);
      chk(16'({ninebit_tx_en, ninebit_rx_en, ninebit_word}), 16'h0002);
      wr(4'h0, 16'h0001);
      ev(4'h4, 9'h15A);
      rc(4'h6, 16'h000C);
      rc(4'h1, 16'h0004);
      rc(4'h8, 16'h015A);
      chk(16'(rx_data_read), 16'h0001);
      rc(4'h6, 16'h0001);
      ev(4'h4, 9'h15B);
      rc(4'h6, 16'h0004);
      rc(4'h8, 16'h015B);
      for (int b = 0; b < 2; b++)
      begin
         wr(4'h5, 16'h00B4 | 16'(b));
         wr(4'h9, 16'h0033);
         chk(16'(tx_ninth_bit), 16'(b));
         chk(16'(tx_data_write), 16'h0001);
      end
      // Empty after an address word reports its own network code.
      wr(4'h0, 16'h0002);
      ev(4'h2, 9'h000);
      rc(4'h6, 16'h000A);
      rc(4'h1, 16'h0002);
      rc(4'h6, 16'h0001);
      wr(4'h5, 16'h00C0);
      chk(16'({ninebit_tx_en, ninebit_rx_en, ninebit_word}), 16'h0004);
      wr(4'h5, 16'h00A8);
      chk(16'({ninebit_tx_en, ninebit_rx_en, ninebit_word}), 16'h0003);
      wr(4'h5, 16'h0068);
      chk(16'({ninebit_tx_en, ninebit_rx_en, ninebit_word}), 16'h0000);
      wr(4'h5, 16'h0080);
      @(negedge clk);
      chk(16'({serial_out_oe, rx_serial}), 16'h0001);
      $display("test network done");
      final_report();
   end
endmodule : tb_uinm_top
